//--- design/gpirq_line_merge.sv
// Folds 32 qualified pins onto eight shared interrupt lines
`timescale 1ns/10ps
module gpirq_line_merge
  import gpirq_pkg::*;
#(
  parameter int PINS  = 32,
  parameter int LINES = 8
) (
  // Per-pin inputs
  input  wire logic [PINS-1:0]  pin_level,
  input  wire logic [PINS-1:0]  pin_pol,
  input  wire logic [PINS-1:0]  pin_en,
  // Shared lines
  output logic      [LINES-1:0] line_out
);

  logic [PINS-1:0] pin_hit;

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_line
      logic [PINS/LINES-1:0] grp;
      genvar k;
      for (k = 0; k < PINS/LINES; k = k + 1) begin : g_pin
        assign grp[k] = pin_hit[g + k*LINES];
      end
      // Pin n to line n mod 8
      assign line_out[g] = |grp;
    end
  endgenerate

  assign pin_hit = pin_en & ~(pin_level ^ pin_pol);

endmodule

//--- design/gpirq_pkg.sv
// Package for the GPIO port with shared interrupt lines
package gpirq_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] GPIRQ_OFS_DRIVE  = 12'h500;
  localparam logic [11:0] GPIRQ_OFS_LEVEL  = 12'h508;
  localparam logic [11:0] GPIRQ_OFS_INTCTL = 12'h510;
  localparam logic [11:0] GPIRQ_OFS_ISTAT  = 12'h518;
  localparam logic [11:0] GPIRQ_OFS_IMASK  = 12'h520;

  // Field positions inside 64-bit registers
  localparam int GPIRQ_LO_LSB = 0;
  localparam int GPIRQ_HI_LSB = 32;

  // Reset values
  localparam logic [31:0] GPIRQ_RST_DRIVE_N = 32'hffffffff;
  localparam logic [31:0] GPIRQ_RST_FUNC_N  = 32'hffff0000;
  localparam logic [31:0] GPIRQ_RST_OUT     = 32'h0;
  localparam logic [31:0] GPIRQ_RST_POL     = 32'h0;
  localparam logic [31:0] GPIRQ_RST_IEN     = 32'h0;
  localparam logic [7:0]  GPIRQ_RST_ISTAT   = 8'h0;
  localparam logic [7:0]  GPIRQ_RST_IMASK   = 8'h0;

  // Geometry
  localparam int GPIRQ_PINS  = 32;
  localparam int GPIRQ_LINES = 8;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [63:0] wdata;
    logic        wr;
    logic        rd;
  } gpirq_bus_s;

  // Pad bundle
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } gpirq_pad_s;

endpackage

//--- design/gpirq_port.sv
// GPIO port: registers, pad drive, input sampling and interrupt lines
// Operation
// - 32 pins, same bit index everywhere
// - 0x500 low half: drive enables, low
// - 0x508 low half: output levels, reset zero
// - 0x510 low half: interrupt polarity per pin
// - 0x510 high half: interrupt enables, high
// - Pins 0-15 reset as undriven inputs
// - Pins 16-31 reset to alternate function, undriven
// - Alternate functions on all 32 pins
// - Pin n feeds line n mod 8
// - Single enabled pin allows edge use
`timescale 1ns/10ps
module gpirq_port
  import gpirq_pkg::*;
#(
  parameter int PINS  = 32,
  parameter int LINES = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Register port
  input  wire logic [11:0]       reg_addr,
  input  wire logic [63:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [63:0]       reg_rdata,
  // Pads
  input  wire logic [PINS-1:0]   pad_in,
  output logic      [PINS-1:0]   pad_out,
  output logic      [PINS-1:0]   pad_oe,
  // Alternate function side
  input  wire logic [PINS-1:0]   alt_out,
  input  wire logic [PINS-1:0]   alt_oe,
  output logic      [PINS-1:0]   alt_in,
  output logic                   serial_periph_select_one,
  output logic                   serial_periph_select_two,
  output logic                   second_serial_receive,
  output logic                   timebase_sync_reset_in_n,
  output logic                   overheat_alert_n,
  output logic                   thermal_shutdown_n,
  // Interrupts
  output logic      [LINES-1:0]  irq_line,
  output logic                   irq
);

  typedef struct packed {
    logic [PINS-1:0]  drive_low;
    logic [PINS-1:0]  func_low;
    logic [PINS-1:0]  out_lvl;
    logic [PINS-1:0]  pol;
    logic [PINS-1:0]  ien;
    logic [PINS-1:0]  sync1;
    logic [PINS-1:0]  sync2;
    logic [LINES-1:0] line_prev;
    logic [LINES-1:0] istat;
    logic [LINES-1:0] imask;
    logic [63:0]      rdata;
    logic [PINS-1:0]  pad_out;
    logic [PINS-1:0]  pad_oe;
  } gpirq_state_s;

  gpirq_state_s st_ff;
  gpirq_state_s nxt_st;
  logic [LINES-1:0] line_w;
  logic [LINES-1:0] line_rise;
  gpirq_bus_s       bus;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  gpirq_line_merge #(
    .PINS  (PINS),
    .LINES (LINES)
  ) u_merge (
    .pin_level (st_ff.sync2),
    .pin_pol   (st_ff.pol),
    .pin_en    (st_ff.ien),
    .line_out  (line_w)
  );

  // Asserting-edge of each shared line
  assign line_rise = line_w & ~st_ff.line_prev;

  always_comb begin
    nxt_st = st_ff;
    // Two-stage pad sampler
    nxt_st.sync1     = pad_in;
    nxt_st.sync2     = st_ff.sync1;
    nxt_st.line_prev = line_w;
    nxt_st.rdata     = 64'h0;
    if (bus.wr) begin
      if (hit(bus.addr, GPIRQ_OFS_DRIVE)) begin
        nxt_st.drive_low = bus.wdata[GPIRQ_LO_LSB +: 32];
        nxt_st.func_low  = bus.wdata[GPIRQ_HI_LSB +: 32];
      end
      if (hit(bus.addr, GPIRQ_OFS_LEVEL)) begin
        nxt_st.out_lvl = bus.wdata[GPIRQ_LO_LSB +: 32];
      end
      if (hit(bus.addr, GPIRQ_OFS_INTCTL)) begin
        nxt_st.pol = bus.wdata[GPIRQ_LO_LSB +: 32];
        nxt_st.ien = bus.wdata[GPIRQ_HI_LSB +: 32];
      end
      if (hit(bus.addr, GPIRQ_OFS_ISTAT)) begin
        nxt_st.istat = st_ff.istat & ~bus.wdata[LINES-1:0];
      end
      if (hit(bus.addr, GPIRQ_OFS_IMASK)) begin
        nxt_st.imask = bus.wdata[LINES-1:0];
      end
    end
    // Set wins over write-one clear
    nxt_st.istat = nxt_st.istat | line_rise;
    if (bus.rd) begin
      case (bus.addr)
        GPIRQ_OFS_DRIVE:  nxt_st.rdata = {st_ff.func_low, st_ff.drive_low};
        GPIRQ_OFS_LEVEL:  nxt_st.rdata = {st_ff.sync2, st_ff.out_lvl};
        GPIRQ_OFS_INTCTL: nxt_st.rdata = {st_ff.ien, st_ff.pol};
        GPIRQ_OFS_ISTAT:  nxt_st.rdata = {56'h0, st_ff.istat};
        GPIRQ_OFS_IMASK:  nxt_st.rdata = {56'h0, st_ff.imask};
        default:          nxt_st.rdata = 64'h0;
      endcase
    end
    // Per-pin pad mux, GPIO or alternate
    nxt_st.pad_oe  = (~nxt_st.drive_low & ~nxt_st.func_low) | (alt_oe & nxt_st.func_low);
    nxt_st.pad_out = (nxt_st.out_lvl & ~nxt_st.func_low) | (alt_out & nxt_st.func_low);
    if (reset) begin
      nxt_st.drive_low = GPIRQ_RST_DRIVE_N;
      nxt_st.func_low  = GPIRQ_RST_FUNC_N;
      nxt_st.out_lvl   = GPIRQ_RST_OUT;
      nxt_st.pol       = GPIRQ_RST_POL;
      nxt_st.ien       = GPIRQ_RST_IEN;
      nxt_st.istat     = GPIRQ_RST_ISTAT;
      nxt_st.imask     = GPIRQ_RST_IMASK;
      nxt_st.line_prev = '0;
      nxt_st.rdata     = 64'h0;
      nxt_st.pad_out   = '0;
      nxt_st.pad_oe    = '0;
      nxt_st.sync1     = '0;
      nxt_st.sync2     = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign reg_rdata = st_ff.rdata;
  assign pad_out   = st_ff.pad_out;
  assign pad_oe    = st_ff.pad_oe;
  assign alt_in                   = st_ff.sync2 & st_ff.func_low;
  assign serial_periph_select_one = alt_out[0];
  assign serial_periph_select_two = alt_out[1];
  assign second_serial_receive    = st_ff.func_low[2] ? st_ff.sync2[2] : 1'b1;
  assign timebase_sync_reset_in_n = st_ff.func_low[13] ? st_ff.sync2[13] : 1'b1;
  assign overheat_alert_n         = st_ff.func_low[14] ? st_ff.sync2[14] : 1'b1;
  assign thermal_shutdown_n       = st_ff.func_low[15] ? st_ff.sync2[15] : 1'b1;
  // Level lines; rising edges latched in istat drive irq where imask is set
  assign irq_line = line_w;
  assign irq      = |(st_ff.istat & st_ff.imask);

  chk_drive_reset: assert property (@(posedge mclk)
    reset
    |=> st_ff.pad_oe == '0 && st_ff.drive_low == GPIRQ_RST_DRIVE_N)
    else $error("pads driven after reset");

  chk_drive_write: assert property (@(posedge mclk)
    disable iff (reset)
    reg_wr && hit(reg_addr, GPIRQ_OFS_DRIVE)
    |=> st_ff.drive_low == $past(reg_wdata[GPIRQ_LO_LSB +: 32]))
    else $error("drive enables not stored");

  chk_gpio_drive: assert property (@(posedge mclk)
    disable iff (reset)
    ((st_ff.pad_oe ^ ~st_ff.drive_low) & ~st_ff.func_low) == '0)
    else $error("GPIO pad drive disagrees with enable");

  chk_func_reset: assert property (@(posedge mclk)
    reset
    |=> st_ff.func_low == GPIRQ_RST_FUNC_N)
    else $error("function select reset wrong");

  chk_func_write: assert property (@(posedge mclk)
    disable iff (reset)
    reg_wr && hit(reg_addr, GPIRQ_OFS_DRIVE)
    |=> st_ff.func_low == $past(reg_wdata[GPIRQ_HI_LSB +: 32]))
    else $error("function selects not stored");

  chk_out_reset: assert property (@(posedge mclk)
    reset
    |=> st_ff.out_lvl == GPIRQ_RST_OUT)
    else $error("output level reset wrong");

  chk_out_write: assert property (@(posedge mclk)
    disable iff (reset)
    reg_wr && hit(reg_addr, GPIRQ_OFS_LEVEL)
    |=> st_ff.out_lvl == $past(reg_wdata[GPIRQ_LO_LSB +: 32]))
    else $error("output level not stored");

  chk_gpio_level: assert property (@(posedge mclk)
    disable iff (reset)
    ((st_ff.pad_out ^ st_ff.out_lvl) & ~st_ff.func_low) == '0)
    else $error("GPIO pad level disagrees with register");

  chk_input_read: assert property (@(posedge mclk)
    disable iff (reset)
    reg_rd && hit(reg_addr, GPIRQ_OFS_LEVEL)
    |=> reg_rdata[GPIRQ_HI_LSB +: 32] == $past(st_ff.sync2))
    else $error("input sample readback wrong");

  chk_intctl_reset: assert property (@(posedge mclk)
    reset
    |=> st_ff.pol == GPIRQ_RST_POL && st_ff.ien == GPIRQ_RST_IEN)
    else $error("interrupt control reset wrong");

  chk_pol_write: assert property (@(posedge mclk)
    disable iff (reset)
    reg_wr && hit(reg_addr, GPIRQ_OFS_INTCTL)
    |=> st_ff.pol == $past(reg_wdata[GPIRQ_LO_LSB +: 32]))
    else $error("polarity not stored");

  chk_ien_write: assert property (@(posedge mclk)
    disable iff (reset)
    reg_wr && hit(reg_addr, GPIRQ_OFS_INTCTL)
    |=> st_ff.ien == $past(reg_wdata[GPIRQ_HI_LSB +: 32]))
    else $error("interrupt enables not stored");

  chk_ien_gate: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.ien == '0
    |-> irq_line == '0)
    else $error("line active with no enables");

  chk_line_reset: assert property (@(posedge mclk)
    reset
    |=> irq_line == '0 && !irq)
    else $error("interrupt active after reset");

  chk_low_undriven: assert property (@(posedge mclk)
    reset ##1 !reset
    |-> pad_oe[15:0] == 16'h0 && st_ff.func_low[15:0] == 16'h0)
    else $error("low pins driven at reset");

  chk_high_undriven: assert property (@(posedge mclk)
    reset ##1 !reset
    |-> pad_oe[PINS-1:16] == '0 && &st_ff.func_low[PINS-1:16])
    else $error("high pins wrong at reset");

  chk_alt_gated: assert property (@(posedge mclk)
    disable iff (reset)
    (alt_in & ~st_ff.func_low) == '0)
    else $error("alternate input leaks in GPIO mode");

  chk_alt_drive: assert property (@(posedge mclk)
    disable iff (reset)
    !$past(reset)
    |-> ((st_ff.pad_oe ^ $past(alt_oe)) & st_ff.func_low) == '0
        && ((st_ff.pad_out ^ $past(alt_out)) & st_ff.func_low) == '0)
    else $error("alternate pad drive wrong");

  chk_rxd_idle: assert property (@(posedge mclk)
    disable iff (reset)
    !st_ff.func_low[2]
    |-> second_serial_receive)
    else $error("serial receive active in GPIO mode");

  chk_alert_idle: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.func_low[15:13] == 3'h0
    |-> timebase_sync_reset_in_n && overheat_alert_n
        && thermal_shutdown_n)
    else $error("sideband input active in GPIO mode");

  for (genvar gl = 0; gl < LINES; gl++) begin : g_chk_line
    logic [PINS/LINES-1:0] exp_hit;
    for (genvar gk = 0; gk < PINS/LINES; gk++) begin : g_pin
      assign exp_hit[gk] = st_ff.ien[gl + gk*LINES]
                         & (st_ff.sync2[gl + gk*LINES] == st_ff.pol[gl + gk*LINES]);
    end
    chk_line_map: assert property (@(posedge mclk)
      disable iff (reset)
      irq_line[gl] == |exp_hit)
      else $error("shared line disagrees with its pins");
  end

  chk_status_set: assert property (@(posedge mclk)
    disable iff (reset)
    |line_rise
    |=> (st_ff.istat & $past(line_rise)) == $past(line_rise))
    else $error("line edge not recorded");

  chk_status_sticky: assert property (@(posedge mclk)
    disable iff (reset)
    !(reg_wr && hit(reg_addr, GPIRQ_OFS_ISTAT))
    |=> ($past(st_ff.istat) & ~st_ff.istat) == '0)
    else $error("status bit lost without clear");

  chk_istat_clear: assert property (@(posedge mclk)
    disable iff (reset)
    reg_wr && hit(reg_addr, GPIRQ_OFS_ISTAT) && line_rise == '0
    |=> (st_ff.istat & $past(reg_wdata[LINES-1:0])) == '0)
    else $error("status bit not cleared");

  chk_irq_masked: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.imask == '0
    |-> !irq)
    else $error("interrupt raised while fully masked");

endmodule

//--- test/gpirq_board.sv
// Board-side model of the devices hanging on the GPIO pads
`timescale 1ns/10ps
module gpirq_board (
  // Port side
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  // Board stimulus
  input  wire logic [31:0] ext_level,
  // Resolved pad levels
  output logic      [31:0] pad_in
);
  assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule

//--- test/gpirq_port_test.sv
// Self-checking bench for the GPIO port with shared interrupt lines
`timescale 1ns/10ps
module gpirq_port_test;
  import gpirq_pkg::*;
  logic        mclk, reset, reg_wr, reg_rd, irq;
  logic [11:0] reg_addr;
  logic [63:0] reg_wdata, reg_rdata;
  logic [31:0] pad_in, pad_out, pad_oe, alt_out, alt_oe, alt_in, ext;
  logic [7:0]  irq_line;
  logic        sel1, sel2, rxd, tsr_n, hot_n, trip_n;
  int          n_errors, n_compared;

  gpirq_port u_gpirq_port (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .alt_out(alt_out),
    .alt_oe(alt_oe), .alt_in(alt_in), .serial_periph_select_one(sel1),
    .serial_periph_select_two(sel2), .second_serial_receive(rxd),
    .timebase_sync_reset_in_n(tsr_n), .overheat_alert_n(hot_n),
    .thermal_shutdown_n(trip_n), .irq_line(irq_line), .irq(irq));
  gpirq_board u_gpirq_board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext),
    .pad_in(pad_in));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic setx(input logic [31:0] v);
    @(posedge mclk);
    ext <= v;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    test_done;
  end
  initial begin
    reset     = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 12'h0;
    reg_wdata = 64'h0;
    ext       = 32'h0;
    alt_out   = 32'h0;
    alt_oe    = 32'h0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(12'h500, 64'hffff0000_ffffffff);
    rd(12'h508, 64'h0);
    rd(12'h510, 64'h0);
    rd(12'h5f8, 64'h0);
    chk({32'h0, pad_oe}, 64'h0);
    // Drive pins 0-7 and loop them back
    setx(32'h12340000);
    wr(12'h500, 64'h00000000_ffffff00);
    wr(12'h508, 64'hffffffff_000000a5);
    wait_n(3);
    chk({pad_oe, pad_out & pad_oe}, 64'h000000ff_000000a5);
    rd(12'h508, 64'h123400a5_000000a5);
    wr(12'h500, 64'h00000000_ffffffff);
    // Every pin, both polarities
    for (int i = 0; i < 32; i++) begin
      for (int p = 0; p < 2; p++) begin
        setx(p ? 32'h0 : 32'hffffffff);
        wr(12'h510, {32'h1 << i, p ? 32'h1 << i : 32'h0});
        wait_n(3);
        chk({56'h0, irq_line}, 64'h0);
        setx(p ? 32'h1 << i : ~(32'h1 << i));
        wait_n(3);
        chk({56'h0, irq_line}, 64'h1 << (i % 8));
      end
    end
    wr(12'h510, 64'h00000000_ffffffff);
    setx(32'hffffffff);
    wait_n(3);
    chk({56'h0, irq_line}, 64'h0);
    rd(12'h518, 64'hff);
    chk({63'h0, irq}, 64'h0);
    wr(12'h520, 64'h08);
    wait_n(2);
    chk({63'h0, irq}, 64'h1);
    wr(12'h518, 64'hff);
    rd(12'h518, 64'h0);
    chk({63'h0, irq}, 64'h0);
    // Single pin on line 3 used as a rising edge
    setx(32'h0);
    wr(12'h510, 64'h00000008_00000008);
    wait_n(3);
    setx(32'h8);
    wait_n(3);
    rd(12'h518, 64'h08);
    chk({63'h0, irq}, 64'h1);
    wr(12'h518, 64'h08);
    rd(12'h518, 64'h0);
    // Pin 14 to its alternate function
    wr(12'h500, 64'h00004000_ffffffff);
    setx(32'h0);
    wait_n(3);
    chk({60'h0, hot_n, trip_n, tsr_n, rxd}, 64'h7);
    setx(32'hffffffff);
    wait_n(3);
    chk({32'h0, alt_in}, 64'h4000);
    chk({60'h0, hot_n, trip_n, tsr_n, rxd}, 64'hf);
    @(posedge mclk);
    alt_oe  <= 32'h4000;
    alt_out <= 32'h4003;
    wait_n(2);
    chk({pad_oe, 30'h0, sel2, sel1}, 64'h00004000_00000003);
    chk({32'h0, pad_out & pad_oe}, 64'h4000);
    test_done;
  end
endmodule
